// ===== gas_sensor_readout_averager_bench.sv
// Self-checking bench of the gas sensor readout averager, driven through the host model.
`timescale 1ns/1ps
`default_nettype none
module gas_sensor_readout_averager_bench;
    localparam int W     = 16;
    localparam int SCYC  = 20;
    localparam int PCYC  = 500;
    localparam int BCYC  = 4;
    localparam int AVGN  = 4;
    localparam int ALPHA = 1094;

    logic                sys_clk  = 1'b0;
    logic                sys_rst  = 1'b1;
    logic                sel_pin  = 1'b1;
    logic signed [W-1:0] gas_raw  = '0;
    logic signed [W-1:0] hum_raw  = '0;
    logic signed [W-1:0] temp_raw = '0;
    logic                cmd_start;
    logic                cmd_stop;
    logic                cmd_read;
    logic                resp_valid;
    logic                resp_data;
    logic [6:0]          resp_err;
    logic signed [W-1:0] gas_out;
    logic signed [W-1:0] hum_out;
    logic signed [W-1:0] temp_out;
    logic                meas_active;
    logic                link_uart;
    logic                baud_tick;
    int                  mismatches   = 0;
    int                  total_checks = 0;
    int                  up_cyc       = 0;
    int                  ph           = 0;
    int                  n            = 0;
    bit                  got          = 0;
    longint              sum[3];
    longint              s[3];
    logic signed [W-1:0] expv[3];
    int                  seed;
    int                  k;

    gsra_top #(.W(W), .SAMPLE_CYC(SCYC), .POWERUP_CYC(PCYC), .BAUD_CYC(BCYC), .AVG_N(AVGN)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sel_pin(sel_pin),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
        .gas_raw(gas_raw), .hum_raw(hum_raw), .temp_raw(temp_raw),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err),
        .gas_out(gas_out), .hum_out(hum_out), .temp_out(temp_out),
        .meas_active(meas_active), .link_uart(link_uart), .baud_tick(baud_tick));

    gsra_host_model host (
        .sys_clk(sys_clk), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err));

    always #2.5 sys_clk = ~sys_clk;

    // ****************************************************************
    // Reference model of the averaging window
    // ****************************************************************
    task automatic add_sample();
        longint x[3];
        x[0] = gas_raw;
        x[1] = hum_raw;
        x[2] = temp_raw;
        n++;
        got = 1'b1;
        for (int c = 0; c < 3; c++) begin
            sum[c] += x[c];
            if (n == AVGN) s[c] = (sum[c] / AVGN) <<< 16;
            else if (n > AVGN) s[c] += (((x[c] <<< 16) - s[c]) * ALPHA) >>> 16;
        end
    endtask : add_sample

    task automatic clr();
        n = 0;
        for (int c = 0; c < 3; c++) begin
            sum[c] = 0;
            s[c]   = 0;
        end
    endtask : clr

    function automatic logic signed [W-1:0] rnd();
        return W'($urandom_range(2000)) - 16'sd1000;
    endfunction : rnd

    // Samples change mid-interval so the tick edge never races the stimulus.
    always @(posedge sys_clk) begin
        if (sys_rst === 1'b0) up_cyc <= up_cyc + 1;
        ph <= (meas_active !== 1'b1 || ph == SCYC - 1) ? 0 : ph + 1;
        if (meas_active === 1'b1 && ph == SCYC - 1) add_sample();
        if (meas_active === 1'b1 && ph == 5) begin
            gas_raw  <= #1 rnd();
            hum_raw  <= #1 rnd();
            temp_raw <= #1 rnd();
        end
    end

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %0b seen %0b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_err(input string nm, input logic [6:0] e, input logic [6:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : cmp_err

    task automatic cmp_val(input string nm, input logic signed [W-1:0] e, input logic signed [W-1:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_val

    task automatic conclude();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wait_ph(input int p);
        for (int i = 0; i < 4 * SCYC && ph != p; i++) cyc(1);
        if (ph != p) begin
            mismatches++;
            conclude();
        end
    endtask : wait_ph

    task automatic send(input int kind, input logic ed, input logic [6:0] ee);
        host.issue(kind);
        cmp_bit("early_valid", 1'b0, host.early);
        cmp_bit("resp_valid", 1'b1, host.got_valid);
        cmp_bit("resp_data", ed, host.got_data);
        cmp_err("resp_err", ee, host.got_err);
    endtask : send

    // The read is taken two edges on and sees the suppression timer as it stood one edge before that.
    task automatic read_chk();
        int  tk;
        tk = up_cyc + 1;
        if (!got) begin
            send(2, 1'b0, 7'h20);
        end else begin
            if (n > 0) begin
                for (int c = 0; c < 3; c++) expv[c] = W'((n < AVGN) ? sum[c] / n : s[c] >>> 16);
                if (tk < PCYC) expv[0] = '0;
                clr();
            end
            send(2, 1'b1, 7'h00);
            cmp_val("hum_out", expv[1], hum_out);
            cmp_val("temp_out", expv[2], temp_out);
            cmp_val("gas_out", expv[0], gas_out);
        end
    endtask : read_chk

    initial begin
        #500000;
        mismatches++;
        conclude();
    end

    initial begin
        seed = $urandom(32'h0a93);
        repeat (5) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        cmp_bit("meas_active", 1'b0, meas_active);
        cmp_bit("link_uart", 1'b1, link_uart);
        cmp_val("gas_out", '0, gas_out);
        $display("Test reset done");
        sel_pin = 1'b0;
        cyc(5);
        cmp_bit("link_uart", 1'b0, link_uart);
        k = 0;
        for (int i = 0; i < 4 * BCYC; i++) begin
            cyc(1);
            k += (baud_tick === 1'b1);
        end
        cmp_val("baud_ticks_i2c", '0, W'(k));
        sel_pin = 1'b1;
        cyc(5);
        cmp_bit("link_uart", 1'b1, link_uart);
        for (int i = 0; i < 2 * BCYC && baud_tick !== 1'b1; i++) cyc(1);
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (baud_tick !== 1'b1 && k < 4 * BCYC);
        cmp_val("baud_period", W'(BCYC), W'(k));
        $display("Test link_select done");
        send(2, 1'b0, 7'h00);
        send(1, 1'b0, 7'h43);
        clr();
        send(0, 1'b0, 7'h00);
        cmp_bit("meas_active", 1'b1, meas_active);
        send(0, 1'b0, 7'h43);
        $display("Test commands done");
        for (int i = 0; i < 14; i++) begin
            k = (i == 1) ? 1 : (i == 3) ? 7 : (i < 4) ? 0 : int'($urandom_range(6));
            if (k > 0) begin
                cyc(k * SCYC);
                wait_ph(8);
            end
            read_chk();
        end
        $display("Test averaging done");
        send(1, 1'b0, 7'h00);
        cmp_bit("meas_active", 1'b0, meas_active);
        send(2, 1'b0, 7'h00);
        cyc(3 * SCYC);
        clr();
        got = 1'b0;
        send(0, 1'b0, 7'h00);
        read_chk();
        cyc(SCYC);
        wait_ph(8);
        read_chk();
        $display("Test stop_restart done");
        conclude();
    end
endmodule : gas_sensor_readout_averager_bench
`default_nettype wire

// ===== gsra_avg_chan.sv
// One averaging channel: arithmetic mean over the window, then exponential smoothing.
`timescale 1ns/1ps
`default_nettype none
`include "gsra_cfg.svh"

module gsra_avg_chan #(
    parameter int W     = 16,
    parameter int AVG_N = `GSRA_AVG_N
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Control
    input  wire logic                clear,
    input  wire logic                sample_en,
    input  wire logic signed [W-1:0] sample_in,
    // Result
    output logic signed [W-1:0]      avg_out,
    output logic                     fresh
);

    localparam int SW = W + 8;
    localparam int EW = W + `GSRA_FRAC_BITS + 1;
    localparam int PW = EW + 17;

    if (AVG_N < 2 || AVG_N > 255 || W < 4) begin : g_bad_param
        $error("gsra_avg_chan: window count or width out of range");
    end

    logic signed [SW-1:0] sum_reg, sum_next;
    logic [7:0]           cnt_reg, cnt_next;
    logic signed [EW-1:0] ema_reg, ema_next;
    logic                 ema_mode_reg, ema_mode_next;

    logic signed [SW-1:0] sum_base;
    logic [7:0]           cnt_base;
    logic signed [SW-1:0] seed_mean;
    logic signed [EW-1:0] diff;
    logic signed [PW-1:0] prod;
    logic signed [SW-1:0] mean;

    // ****************************************************************
    // Next-state computation
    // ****************************************************************
    always_comb begin
        sum_base      = clear ? '0 : sum_reg;
        cnt_base      = clear ? 8'h00 : cnt_reg;
        sum_next      = sum_base;
        cnt_next      = cnt_base;
        ema_next      = clear ? '0 : ema_reg;
        ema_mode_next = clear ? 1'b0 : ema_mode_reg;
        seed_mean     = SW'((sum_base + SW'(sample_in)) / $signed({1'b0, SW'(AVG_N)}));
        diff          = $signed({sample_in, {`GSRA_FRAC_BITS{1'b0}}}) - ema_reg;
        prod          = PW'(diff) * $signed({{(PW-17){1'b0}}, `GSRA_ALPHA_Q16});
        // A sample in the clearing cycle opens the new window, so it is never lost.
        if (sample_en) begin
            if (ema_mode_next) begin
                ema_next = ema_reg + EW'(prod >>> `GSRA_FRAC_BITS);
            end else if (cnt_base == 8'(AVG_N - 1)) begin
                ema_next      = EW'($signed({W'(seed_mean), {`GSRA_FRAC_BITS{1'b0}}}));
                ema_mode_next = 1'b1;
                cnt_next      = 8'(AVG_N);
            end else begin
                sum_next = sum_base + SW'(sample_in);
                cnt_next = cnt_base + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sum_reg      <= '0;
            cnt_reg      <= 8'h00;
            ema_reg      <= '0;
            ema_mode_reg <= 1'b0;
        end else begin
            sum_reg      <= sum_next;
            cnt_reg      <= cnt_next;
            ema_reg      <= ema_next;
            ema_mode_reg <= ema_mode_next;
        end
    end

    // ****************************************************************
    // Reported value
    // ****************************************************************
    always_comb begin
        mean = (cnt_reg == 8'h00) ? '0 : SW'(sum_reg / $signed({1'b0, SW'(cnt_reg)}));
        if (ema_mode_reg) begin
            avg_out = ema_reg[W+`GSRA_FRAC_BITS-1:`GSRA_FRAC_BITS];
        end else begin
            avg_out = W'(mean);
        end
        fresh = (cnt_reg != 8'h00) || ema_mode_reg;
    end

    AST_SEED_AT_WINDOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (sample_en && !clear && !ema_mode_reg && cnt_reg == 8'(AVG_N - 1)) |=> ema_mode_reg)
        else $error("smoothing not seeded at end of window");

endmodule : gsra_avg_chan

`default_nettype wire

// ===== gsra_cfg.svh
// Timing, window, error code and link constants of the gas sensor readout averager.
`ifndef GSRA_CFG_SVH
`define GSRA_CFG_SVH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define GSRA_CLK_KHZ        200000
`define GSRA_SAMPLE_MS      500
`define GSRA_WINDOW_MS      60000
`define GSRA_POWERUP_MS     10000
`define GSRA_SAMPLE_CYC     (`GSRA_SAMPLE_MS * `GSRA_CLK_KHZ)
`define GSRA_POWERUP_CYC    (`GSRA_POWERUP_MS * `GSRA_CLK_KHZ)
`define GSRA_AVG_N          (`GSRA_WINDOW_MS / `GSRA_SAMPLE_MS)

// ****************************************************************
// Serial link figures
// ****************************************************************
`define GSRA_UART_BAUD      115200
`define GSRA_UART_DATA_BITS 8
`define GSRA_UART_STOP_BITS 1
`define GSRA_BAUD_CYC       ((`GSRA_CLK_KHZ * 1000) / `GSRA_UART_BAUD)

// ****************************************************************
// Smoothing factor 0.0167 in unsigned Q0.16
// ****************************************************************
`define GSRA_ALPHA_Q16      17'h00446
`define GSRA_FRAC_BITS      16

// ****************************************************************
// Response error codes and reset values
// ****************************************************************
`define GSRA_ERR_NONE       7'h00
`define GSRA_ERR_NODATA     7'h20
`define GSRA_ERR_STATE      7'h43
`define GSRA_SEL_RST        1'b1

`endif

// ===== gsra_host_model.sv
// Host-side model that issues command pulses and captures each answer.
`timescale 1ns/1ps
`default_nettype none
module gsra_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Command pulses
    output var logic        cmd_start,
    output var logic        cmd_stop,
    output var logic        cmd_read,
    // Answer
    input  wire logic       resp_valid,
    input  wire logic       resp_data,
    input  wire logic [6:0] resp_err
);
    logic       early;
    logic       got_valid;
    logic       got_data;
    logic [6:0] got_err;

    initial begin
        cmd_start = 1'b0;
        cmd_stop  = 1'b0;
        cmd_read  = 1'b0;
    end

    // One command in flight at a time, so a stale answer can never be taken for a new one.
    task automatic issue(input int kind);
        @(posedge sys_clk);
        #1;
        early     = resp_valid;
        cmd_start = (kind == 0);
        cmd_stop  = (kind == 1);
        cmd_read  = (kind == 2);
        @(posedge sys_clk);
        #1;
        cmd_start = 1'b0;
        cmd_stop  = 1'b0;
        cmd_read  = 1'b0;
        got_valid = resp_valid;
        got_data  = resp_data;
        got_err   = resp_err;
    endtask : issue
endmodule : gsra_host_model
`default_nettype wire

// ===== gsra_pkg.sv
// Types shared by the gas sensor readout averager.
`default_nettype none
package gsra_pkg;

    typedef enum logic [0:0] {
        GSRA_IDLE = 1'b0,
        GSRA_MEAS = 1'b1
    } gsra_state_t;

endpackage : gsra_pkg

`default_nettype wire

// ===== gsra_top.sv
// Measurement sequencing, readout averaging and power-up gas suppression of the sensor module.
// Behaviour
// - Select pin high or floating: UART, low: I2C.
// - UART runs 115200 baud, 8N1.
// - Idle after power-up until start command.
// - Measuring mode samples every half second.
// - Readout reports average since previous readout.
// - Under sixty seconds: plain arithmetic mean.
// - Beyond sixty seconds: seeded exponential smoothing.
// - First half second after start: no data.
// - Early read answers error 32, empty.
// - No new sample: repeat last data.
// - Gas output zero for ten seconds after power-up.
// - Humidity and temperature never suppressed.
// - Stop command returns to idle, no sampling.
`timescale 1ns/1ps
`default_nettype none
`include "gsra_cfg.svh"

module gsra_top #(
    parameter int          W           = 16,
    parameter int unsigned SAMPLE_CYC  = `GSRA_SAMPLE_CYC,
    parameter int unsigned POWERUP_CYC = `GSRA_POWERUP_CYC,
    parameter int unsigned BAUD_CYC    = `GSRA_BAUD_CYC,
    parameter int          AVG_N       = `GSRA_AVG_N
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Interface select pin
    input  wire logic                sel_pin,
    // Decoded host commands, one-cycle pulses
    input  wire logic                cmd_start,
    input  wire logic                cmd_stop,
    input  wire logic                cmd_read,
    // Raw samples from the sensing front end
    input  wire logic signed [W-1:0] gas_raw,
    input  wire logic signed [W-1:0] hum_raw,
    input  wire logic signed [W-1:0] temp_raw,
    // Command response
    output logic                     resp_valid,
    output logic                     resp_data,
    output logic [6:0]               resp_err,
    output logic signed [W-1:0]      gas_out,
    output logic signed [W-1:0]      hum_out,
    output logic signed [W-1:0]      temp_out,
    // Status and link
    output logic                     meas_active,
    output logic                     link_uart,
    output logic                     baud_tick
);

    if (SAMPLE_CYC < 2 || POWERUP_CYC < 2 || BAUD_CYC < 2) begin : g_bad_param
        $error("gsra_top: timing counts must be at least two cycles");
    end

    gsra_pkg::gsra_state_t state_reg, state_next;
    logic [31:0]          tick_cnt_reg, tick_cnt_next;
    logic [31:0]          pu_cnt_reg, pu_cnt_next;
    logic                 pu_done_reg, pu_done_next;
    logic                 have_reg, have_next;
    logic                 sel_meta_reg, sel_sync_reg;
    logic                 link_uart_reg, link_uart_next;
    logic [31:0]          baud_cnt_reg, baud_cnt_next;
    logic                 baud_tick_reg, baud_tick_next;
    logic                 resp_valid_reg, resp_valid_next;
    logic                 resp_data_reg, resp_data_next;
    logic [6:0]           resp_err_reg, resp_err_next;
    logic signed [W-1:0]  gas_out_reg, gas_out_next;
    logic signed [W-1:0]  hum_out_reg, hum_out_next;
    logic signed [W-1:0]  temp_out_reg, temp_out_next;
    logic                 samp_tick;
    logic                 avg_clear;
    logic signed [W-1:0]  gas_avg, hum_avg, temp_avg;
    logic                 gas_fresh, hum_fresh, temp_fresh;
    logic                 fresh;

    assign fresh = gas_fresh | hum_fresh | temp_fresh;

    // ****************************************************************
    // Averaging channels
    // ****************************************************************
    gsra_avg_chan #(.W(W), .AVG_N(AVG_N)) u_gas (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (avg_clear),
        .sample_en (samp_tick),
        .sample_in (gas_raw),
        .avg_out   (gas_avg),
        .fresh     (gas_fresh)
    );

    gsra_avg_chan #(.W(W), .AVG_N(AVG_N)) u_hum (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (avg_clear),
        .sample_en (samp_tick),
        .sample_in (hum_raw),
        .avg_out   (hum_avg),
        .fresh     (hum_fresh)
    );

    gsra_avg_chan #(.W(W), .AVG_N(AVG_N)) u_temp (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (avg_clear),
        .sample_en (samp_tick),
        .sample_in (temp_raw),
        .avg_out   (temp_avg),
        .fresh     (temp_fresh)
    );

    // ****************************************************************
    // Link select and baud enable
    // ****************************************************************
    always_comb begin
        link_uart_next = sel_sync_reg;
        baud_cnt_next  = 32'h0000_0000;
        baud_tick_next = 1'b0;
        // The divider only runs on the UART link; on I2C the bit clock comes from the host.
        if (link_uart_reg) begin
            if (baud_cnt_reg == BAUD_CYC - 32'h1) begin
                baud_tick_next = 1'b1;
            end else begin
                baud_cnt_next = baud_cnt_reg + 32'h1;
            end
        end
    end

    // ****************************************************************
    // Sequencing, readout and power-up suppression
    // ****************************************************************
    always_comb begin
        state_next      = state_reg;
        tick_cnt_next   = tick_cnt_reg;
        pu_cnt_next     = pu_cnt_reg;
        pu_done_next    = pu_done_reg;
        have_next       = have_reg;
        resp_valid_next = 1'b0;
        resp_data_next  = 1'b0;
        resp_err_next   = `GSRA_ERR_NONE;
        gas_out_next    = gas_out_reg;
        hum_out_next    = hum_out_reg;
        temp_out_next   = temp_out_reg;
        samp_tick       = 1'b0;
        avg_clear       = 1'b0;

        // The suppression timer runs from reset, whatever the measuring state.
        if (!pu_done_reg) begin
            pu_cnt_next = pu_cnt_reg + 32'h1;
            if (pu_cnt_reg == POWERUP_CYC - 32'h1) begin
                pu_done_next = 1'b1;
            end
        end

        if (state_reg == gsra_pkg::GSRA_MEAS) begin
            if (tick_cnt_reg == SAMPLE_CYC - 32'h1) begin
                tick_cnt_next = 32'h0000_0000;
                samp_tick     = 1'b1;
                have_next     = 1'b1;
            end else begin
                tick_cnt_next = tick_cnt_reg + 32'h1;
            end
        end

        if (cmd_start) begin
            resp_valid_next = 1'b1;
            if (state_reg == gsra_pkg::GSRA_IDLE) begin
                state_next    = gsra_pkg::GSRA_MEAS;
                tick_cnt_next = 32'h0000_0000;
                have_next     = 1'b0;
                avg_clear     = 1'b1;
            end else begin
                resp_err_next = `GSRA_ERR_STATE;
            end
        end else if (cmd_stop) begin
            resp_valid_next = 1'b1;
            if (state_reg == gsra_pkg::GSRA_MEAS) begin
                state_next = gsra_pkg::GSRA_IDLE;
                have_next  = 1'b0;
            end else begin
                resp_err_next = `GSRA_ERR_STATE;
            end
        end else if (cmd_read) begin
            resp_valid_next = 1'b1;
            if (state_reg == gsra_pkg::GSRA_IDLE) begin
                resp_data_next = 1'b0;
            end else if (!have_reg) begin
                resp_err_next = `GSRA_ERR_NODATA;
            end else begin
                resp_data_next = 1'b1;
                // Without a new sample the held values go out again untouched.
                if (fresh) begin
                    gas_out_next  = pu_done_reg ? gas_avg : '0;
                    hum_out_next  = hum_avg;
                    temp_out_next = temp_avg;
                    avg_clear     = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg      <= gsra_pkg::GSRA_IDLE;
            tick_cnt_reg   <= 32'h0000_0000;
            pu_cnt_reg     <= 32'h0000_0000;
            pu_done_reg    <= 1'b0;
            have_reg       <= 1'b0;
            sel_meta_reg   <= `GSRA_SEL_RST;
            sel_sync_reg   <= `GSRA_SEL_RST;
            link_uart_reg  <= `GSRA_SEL_RST;
            baud_cnt_reg   <= 32'h0000_0000;
            baud_tick_reg  <= 1'b0;
            resp_valid_reg <= 1'b0;
            resp_data_reg  <= 1'b0;
            resp_err_reg   <= `GSRA_ERR_NONE;
            gas_out_reg    <= '0;
            hum_out_reg    <= '0;
            temp_out_reg   <= '0;
        end else begin
            state_reg      <= state_next;
            tick_cnt_reg   <= tick_cnt_next;
            pu_cnt_reg     <= pu_cnt_next;
            pu_done_reg    <= pu_done_next;
            have_reg       <= have_next;
            sel_meta_reg   <= sel_pin;
            sel_sync_reg   <= sel_meta_reg;
            link_uart_reg  <= link_uart_next;
            baud_cnt_reg   <= baud_cnt_next;
            baud_tick_reg  <= baud_tick_next;
            resp_valid_reg <= resp_valid_next;
            resp_data_reg  <= resp_data_next;
            resp_err_reg   <= resp_err_next;
            gas_out_reg    <= gas_out_next;
            hum_out_reg    <= hum_out_next;
            temp_out_reg   <= temp_out_next;
        end
    end

    assign resp_valid  = resp_valid_reg;
    assign resp_data   = resp_data_reg;
    assign resp_err    = resp_err_reg;
    assign gas_out     = gas_out_reg;
    assign hum_out     = hum_out_reg;
    assign temp_out    = temp_out_reg;
    assign meas_active = (state_reg == gsra_pkg::GSRA_MEAS);
    assign link_uart   = link_uart_reg;
    assign baud_tick   = baud_tick_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_SEL_FOLLOWS_PIN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!sel_pin)[*3] |=> !link_uart_reg)
        else $error("grounded select pin did not choose I2C");

    AST_IDLE_NO_SAMPLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_reg == gsra_pkg::GSRA_IDLE) |-> !samp_tick)
        else $error("sample taken while idle");

    AST_START_FIRST_TICK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_start && state_reg == gsra_pkg::GSRA_IDLE) |=> !have_reg ##0 (tick_cnt_reg == 32'h0))
        else $error("start did not restart the sample period");

    AST_EARLY_READ_ERR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_read && !cmd_start && !cmd_stop && state_reg == gsra_pkg::GSRA_MEAS && !have_reg)
        |=> resp_valid_reg && !resp_data_reg && resp_err_reg == 7'h20)
        else $error("early read did not answer error 32");

    AST_STALE_REPEATS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_read && !cmd_start && !cmd_stop && have_reg && !fresh)
        |=> resp_data_reg && $stable(hum_out_reg) && $stable(temp_out_reg))
        else $error("stale read changed the reported values");

    AST_GAS_SUPPRESSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_read && !cmd_start && !cmd_stop && have_reg && fresh && !pu_done_reg) |=> gas_out_reg == '0)
        else $error("gas reported during power-up hold-off");

    AST_HUM_NOT_HELD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_read && !cmd_start && !cmd_stop && have_reg && fresh) |=> hum_out_reg == $past(hum_avg))
        else $error("humidity not reported from the average");

    AST_STOP_TO_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_stop && !cmd_start && state_reg == gsra_pkg::GSRA_MEAS)
        |=> (state_reg == gsra_pkg::GSRA_IDLE && !samp_tick) ##1 !samp_tick)
        else $error("stop did not return to idle");

    AST_READ_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd_read && !cmd_start && !cmd_stop && have_reg && fresh && !samp_tick) |=> !fresh)
        else $error("fresh readout did not clear the window");

endmodule : gsra_top

`default_nettype wire
